// File: core/pbus_bridge_end.sv
// Bridge end: processor bus master/slave with internal or external arbiter
`timescale 1ns/100ps
`default_nettype none
`include "pbus_defines.svh"
// How it works
// [R01] Slave asserts address acknowledge ending address tenure
// [R02] Retry makes the master abandon and retry
// [R03] Address master drives address parity lines
// [R04] Address bus driven only while bridge masters
// [R05] First address grant: input external, output internal
// [R06] Extra address grants are internal-arbiter outputs
// [R07] First request: output external, input internal
// [R08] External masters request on extra request inputs
// [R09] Bridge master drives cache inhibit
// [R10] Everything synchronous to one bus clock
// [R11] Data bus owner asserts data bus busy
// [R12] First data grant direction follows arbiter choice
// [R13] Slave drives data parity reads, master writes
// [R14] Data valid only with valid beat
// [R15] Fast-clock strap sampled at power-up
// [R16] Coherent bridge transfers assert global
// [R17] Reset-config strobe loads power-up options
// [R18] Reset direction strap drives reset line low
// [R19] One acknowledge per beat, burst four
// [R20] Master marks bursts with burst marker
// [R21] Bus errors signalled with transfer error
// [R22] Transfer start marks address tenure with qualifiers
// [R23] Little-endian slave errors misaligned sizes
// [R24] Internal arbiter grants at most one each
module pbus_bridge_end
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	pbus_if.bridge bus,
	input wire logic internal_arb_i,
	input wire logic little_endian_i,
	input wire logic reset_direction_strap_i,
	input wire logic pll_range_strap_i,
	output logic pll_fast_range_o,
	output logic options_loaded_o,
	input wire logic mst_valid_i,
	output logic mst_ready_o,
	input wire logic [`PB_ADDR_W-1:0] mst_addr_i,
	input wire logic [`PB_TSIZ_W-1:0] mst_size_i,
	input wire logic [`PB_TT_W-1:0] mst_type_i,
	input wire logic mst_burst_i,
	input wire logic mst_inhibit_i,
	input wire logic [`PB_DATA_W-1:0] mst_wdata_i,
	output logic mst_done_o,
	output logic mst_err_o,
	output logic [`PB_DATA_W-1:0] mst_rdata_o,
	output logic slv_wvalid_o,
	output logic [`PB_ADDR_W-1:0] slv_addr_o,
	output logic [`PB_DATA_W-1:0] slv_wdata_o,
	input wire logic [`PB_DATA_W-1:0] slv_rdata_i
);
	pbus_pkg::mst_state_t st_ff, nxt_st;
	pbus_pkg::slv_state_t sl_ff, nxt_sl;
	logic [2:0] beat_ff, nxt_beat, sl_left_ff, nxt_sl_left;
	logic [`PB_ADDR_W-1:0] addr_ff, nxt_addr, sl_addr_ff, nxt_sl_addr;
	logic [`PB_TSIZ_W-1:0] size_ff, nxt_size;
	logic [`PB_TT_W-1:0] type_ff, nxt_type;
	logic burst_ff, nxt_burst, inh_ff, nxt_inh, done_ff, nxt_done;
	logic err_ff, nxt_err, sl_rd_ff, nxt_sl_rd, sl_wv_ff, nxt_sl_wv;
	logic [`PB_DATA_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [`PB_DATA_W-1:0] sl_wdata_ff, nxt_sl_wdata;
	logic fast_ff, nxt_fast, loaded_ff, nxt_loaded;
	logic [2:0] abg_ff, nxt_abg, dbg_ff, nxt_dbg;
	logic [2:0] reqs;
	logic addr_granted, data_granted, is_read, sl_start;

	////////////////////////////////////////////////////////////////////
	// Internal arbiter, fixed priority, one grant of each kind [R24]
	assign reqs = {!bus.br_ext_n[1], !bus.br_ext_n[0], !bus.br1_n}; // [R08]
	always_comb
	begin
		nxt_abg = 3'h0;
		nxt_dbg = dbg_ff;
		if (internal_arb_i && bus.dbb_n && st_ff == pbus_pkg::ST_IDLE)
		begin
			if (reqs[0])
				nxt_abg = 3'h1;
			else if (reqs[1])
				nxt_abg = 3'h2;
			else if (reqs[2])
				nxt_abg = 3'h4;
		end
		// Data grant follows the address grant holder [R24]
		if (!internal_arb_i)
			nxt_dbg = 3'h0;
		else if (abg_ff != 3'h0)
			nxt_dbg = abg_ff;
		else if (bus.dbb_n && bus.ts_n)
			nxt_dbg = 3'h0;
	end
	// Bridge owns the bus itself when internal arbiter is idle
	assign addr_granted = internal_arb_i ? (reqs == 3'h0 && abg_ff == 3'h0)
		: !bus.bg1_n; // [R05]
	assign data_granted = internal_arb_i ? 1'b1 : !bus.dbg1_n; // [R12]

	////////////////////////////////////////////////////////////////////
	// Master sequencing
	assign is_read = type_ff[`PB_TT_READ_BIT];
	always_comb
	begin
		nxt_st = st_ff;
		{nxt_beat, nxt_addr, nxt_size, nxt_type} =
			{beat_ff, addr_ff, size_ff, type_ff};
		{nxt_burst, nxt_inh, nxt_wdata, nxt_rdata} =
			{burst_ff, inh_ff, wdata_ff, rdata_ff};
		{nxt_done, nxt_err} = 2'h0;
		case (st_ff)
			pbus_pkg::ST_IDLE:
				if (mst_valid_i && loaded_ff)
				begin
					nxt_addr = mst_addr_i;
					nxt_size = mst_size_i;
					nxt_type = mst_type_i;
					nxt_burst = mst_burst_i;
					nxt_inh = mst_inhibit_i;
					nxt_wdata = mst_wdata_i;
					nxt_st = pbus_pkg::ST_REQ;
				end
			pbus_pkg::ST_REQ:
				if (addr_granted && bus.dbb_n && sl_ff == pbus_pkg::SL_IDLE)
					nxt_st = pbus_pkg::ST_ADDR;
			pbus_pkg::ST_ADDR:
				if (!bus.artry_n)
					nxt_st = pbus_pkg::ST_REQ; // Abandon, retry later [R02]
				else if (!bus.aack_n)
				begin
					nxt_beat = 3'h0;
					nxt_st = pbus_pkg::ST_DATA;
				end
			pbus_pkg::ST_DATA:
				if (!bus.artry_n)
					nxt_st = pbus_pkg::ST_REQ; // [R02]
				else if (!bus.tea_n)
				begin
					nxt_err = 1'b1; // [R21]
					nxt_st = pbus_pkg::ST_DONE;
				end
				else if (!bus.ta_n && data_granted)
				begin
					if (is_read)
						nxt_rdata = bus.data;
					nxt_beat = beat_ff + 3'h1;
					if (!burst_ff || beat_ff == `PB_BURST_BEATS - 3'h1)
					begin
						nxt_done = 1'b1; // [R19]
						nxt_st = pbus_pkg::ST_DONE;
					end
				end
			pbus_pkg::ST_DONE:
				nxt_st = pbus_pkg::ST_IDLE;
			default:
				nxt_st = pbus_pkg::ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Slave: acknowledge the address, then beats or an error
	assign sl_start = !bus.ts_n && st_ff != pbus_pkg::ST_ADDR &&
		sl_ff == pbus_pkg::SL_IDLE;
	always_comb
	begin
		nxt_sl = sl_ff;
		nxt_sl_left = sl_left_ff;
		nxt_sl_rd = sl_rd_ff;
		nxt_sl_addr = sl_addr_ff;
		nxt_sl_wdata = sl_wdata_ff;
		nxt_sl_wv = 1'b0;
		case (sl_ff)
			pbus_pkg::SL_IDLE:
				if (sl_start)
				begin
					nxt_sl_rd = bus.tt[`PB_TT_READ_BIT];
					nxt_sl_addr = bus.addr;
					nxt_sl_left = bus.tbst_n ? 3'h1 : `PB_BURST_BEATS;
					if (little_endian_i && (bus.tsiz inside {4'h3, 4'h5,
						4'h6, 4'h7} || (bus.tsiz == 4'h2 && bus.addr[0])))
						nxt_sl = pbus_pkg::SL_ERR; // [R23]
					else
						nxt_sl = pbus_pkg::SL_DATA;
				end
			pbus_pkg::SL_DATA:
			begin
				if (!sl_rd_ff)
				begin
					nxt_sl_wdata = bus.data;
					nxt_sl_wv = 1'b1;
				end
				nxt_sl_left = sl_left_ff - 3'h1;
				if (sl_left_ff == 3'h1)
					nxt_sl = pbus_pkg::SL_IDLE;
			end
			pbus_pkg::SL_ERR:
				nxt_sl = pbus_pkg::SL_IDLE;
			default:
				nxt_sl = pbus_pkg::SL_IDLE;
		endcase
	end

	// Straps caught on the clock while the shared reset line is low
	always_comb
	begin
		nxt_fast = fast_ff;
		nxt_loaded = loaded_ff;
		if (!bus.rst_n)
		begin
			nxt_fast = pll_range_strap_i; // [R15]
			nxt_loaded = 1'b1; // [R17]
		end
	end

	// All state registered on the single bus clock [R10]
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_ff <= pbus_pkg::ST_IDLE;
			sl_ff <= pbus_pkg::SL_IDLE;
			{beat_ff, sl_left_ff, abg_ff, dbg_ff} <= 12'h000;
			{addr_ff, sl_addr_ff} <= 64'h0;
			size_ff <= 4'h0;
			type_ff <= 5'h00;
			{burst_ff, inh_ff, done_ff, err_ff, sl_rd_ff, sl_wv_ff} <= 6'h00;
			{wdata_ff, rdata_ff, sl_wdata_ff} <= 192'h0;
			fast_ff <= nxt_fast;
			loaded_ff <= !bus.rst_n; // Strap drive during reset loads
		end
		else
		begin
			st_ff <= nxt_st;
			sl_ff <= nxt_sl;
			{beat_ff, sl_left_ff, abg_ff, dbg_ff} <=
				{nxt_beat, nxt_sl_left, nxt_abg, nxt_dbg};
			{addr_ff, sl_addr_ff} <= {nxt_addr, nxt_sl_addr};
			size_ff <= nxt_size;
			type_ff <= nxt_type;
			{burst_ff, inh_ff, done_ff, err_ff, sl_rd_ff, sl_wv_ff} <=
				{nxt_burst, nxt_inh, nxt_done, nxt_err, nxt_sl_rd, nxt_sl_wv};
			{wdata_ff, rdata_ff, sl_wdata_ff} <=
				{nxt_wdata, nxt_rdata, nxt_sl_wdata};
			fast_ff <= nxt_fast;
			loaded_ff <= nxt_loaded;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drive
	assign mst_ready_o = (st_ff == pbus_pkg::ST_IDLE) && loaded_ff;
	assign mst_done_o = done_ff;
	assign mst_err_o = err_ff;
	assign mst_rdata_o = rdata_ff;
	assign slv_wvalid_o = sl_wv_ff;
	assign slv_addr_o = sl_addr_ff;
	assign slv_wdata_o = sl_wdata_ff;
	assign pll_fast_range_o = fast_ff;
	assign options_loaded_o = loaded_ff;
	// Arbitration pins swap direction with the arbiter choice
	assign bus.b_arb_oe = internal_arb_i; // [R05]
	assign bus.b_bg1_n = !abg_ff[0]; // [R05]
	assign bus.b_bg_ext_n = internal_arb_i ? ~abg_ff[2:1] : 2'h3; // [R06]
	assign bus.b_dbg1_n = !dbg_ff[0]; // [R12]
	assign bus.b_dbg_ext_n = internal_arb_i ? ~dbg_ff[2:1] : 2'h3;
	assign bus.b_br1_n = !(st_ff == pbus_pkg::ST_REQ); // [R07]
	// Address tenure
	assign bus.b_addr_oe = (st_ff == pbus_pkg::ST_ADDR); // [R04]
	assign bus.b_addr = addr_ff;
	assign bus.b_ap = {^addr_ff[31:24], ^addr_ff[23:16], ^addr_ff[15:8],
		^addr_ff[7:0]}; // [R03]
	// Start is one cycle: the slave answers in the same cycle [R22]
	assign bus.b_ts_n = !(st_ff == pbus_pkg::ST_ADDR);
	assign bus.b_tsiz = size_ff;
	assign bus.b_tt = type_ff;
	assign bus.b_tbst_n = !burst_ff; // [R20]
	assign bus.b_ci_n = !inh_ff; // [R09]
	assign bus.b_gbl_n = !type_ff[`PB_TT_COHERENT_BIT]; // [R16]
	assign bus.b_dbb_n = !(st_ff == pbus_pkg::ST_DATA); // [R11]
	// Data: master writes, slave reads, parity follows the driver [R13]
	assign bus.b_data_oe = (st_ff == pbus_pkg::ST_DATA && !is_read) ||
		(sl_ff == pbus_pkg::SL_DATA && sl_rd_ff);
	assign bus.b_data = (sl_ff == pbus_pkg::SL_DATA) ? slv_rdata_i :
		wdata_ff;
	for (genvar g = 0; g < `PB_DPAR_W; g++)
	begin : g_dpar
		assign bus.b_dp[g] = ^bus.b_data[g*8 +: 8];
	end
	// Slave answers
	assign bus.b_resp_oe = sl_start || sl_ff != pbus_pkg::SL_IDLE;
	assign bus.b_aack_n = !sl_start; // [R01]
	assign bus.b_artry_n = 1'b1;
	assign bus.b_dresp_oe = sl_ff != pbus_pkg::SL_IDLE;
	assign bus.b_ta_n = !(sl_ff == pbus_pkg::SL_DATA); // [R19]
	assign bus.b_tea_n = !(sl_ff == pbus_pkg::SL_ERR); // [R21] [R23]
	assign bus.b_dval_n = !(sl_ff == pbus_pkg::SL_DATA && sl_rd_ff); // [R14]
	// Reset line pulled low during reset only when strap says so [R18]
	assign bus.b_rst_oe = !reset_n_i && reset_direction_strap_i;
	assign bus.b_rst_n = 1'b0;
endmodule : pbus_bridge_end
`default_nettype wire

// File: core/pbus_defines.svh
// Constants shared by both ends of the processor bus link
`ifndef PBUS_DEFINES_SVH
`define PBUS_DEFINES_SVH
`define PB_ADDR_W 32
`define PB_DATA_W 64
`define PB_APAR_W 4
`define PB_DPAR_W 8
`define PB_TSIZ_W 4
`define PB_TT_W 5
`define PB_BURST_BEATS 3'h4
`define PROC_BUS_CLOCK_MHZ 25
`define PLL_RANGE_STRAP_SPLIT_MHZ 50
`define PB_TT_READ_BIT 3
`define PB_TT_COHERENT_BIT 0
`endif

// File: core/pbus_pkg.sv
// Types shared by both ends of the processor bus link
package pbus_pkg;
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_REQ = 5'h02,
		ST_ADDR = 5'h04,
		ST_DATA = 5'h08,
		ST_DONE = 5'h10
	} mst_state_t;
	typedef enum logic [2:0]
	{
		SL_IDLE = 3'h1,
		SL_DATA = 3'h2,
		SL_ERR = 3'h4
	} slv_state_t;
endpackage : pbus_pkg

// File: core/pbus_if.sv
// Processor bus wires joining bridge end and processor end
`timescale 1ns/100ps
`default_nettype none
`include "pbus_defines.svh"
interface pbus_if;
	// Resolved wire levels
	logic ts_n, aack_n, artry_n, tbst_n, ta_n, tea_n, dval_n;
	logic dbb_n, ci_n, gbl_n, br1_n, bg1_n, dbg1_n, rst_n;
	logic [`PB_ADDR_W-1:0] addr;
	logic [`PB_APAR_W-1:0] ap;
	logic [`PB_DATA_W-1:0] data;
	logic [`PB_DPAR_W-1:0] dp;
	logic [`PB_TSIZ_W-1:0] tsiz;
	logic [`PB_TT_W-1:0] tt;
	// Bridge drive values and enables
	logic b_ts_n, b_aack_n, b_artry_n, b_tbst_n, b_ta_n, b_tea_n, b_dval_n;
	logic b_dbb_n, b_ci_n, b_gbl_n, b_br1_n, b_bg1_n, b_dbg1_n, b_rst_n;
	logic b_addr_oe, b_data_oe, b_resp_oe, b_dresp_oe, b_arb_oe, b_rst_oe;
	logic [1:0] b_bg_ext_n, b_dbg_ext_n, br_ext_n;
	logic [`PB_ADDR_W-1:0] b_addr;
	logic [`PB_APAR_W-1:0] b_ap;
	logic [`PB_DATA_W-1:0] b_data;
	logic [`PB_DPAR_W-1:0] b_dp;
	logic [`PB_TSIZ_W-1:0] b_tsiz;
	logic [`PB_TT_W-1:0] b_tt;
	// Processor drive values and enables
	logic p_ts_n, p_tbst_n, p_ta_n, p_tea_n, p_dval_n, p_aack_n, p_artry_n;
	logic p_dbb_n, p_br1_n, p_rst_n;
	logic p_addr_oe, p_data_oe, p_resp_oe, p_dresp_oe, p_br_oe, p_rst_oe;
	logic [`PB_ADDR_W-1:0] p_addr;
	logic [`PB_APAR_W-1:0] p_ap;
	logic [`PB_DATA_W-1:0] p_data;
	logic [`PB_DPAR_W-1:0] p_dp;
	logic [`PB_TSIZ_W-1:0] p_tsiz;
	logic [`PB_TT_W-1:0] p_tt;
	modport bridge
	(
		input ts_n, aack_n, artry_n, tbst_n, ta_n, tea_n, dval_n, dbb_n,
		input br1_n, bg1_n, dbg1_n, rst_n, addr, data, tsiz, tt, br_ext_n,
		output b_ts_n, b_aack_n, b_artry_n, b_tbst_n, b_ta_n, b_tea_n,
		output b_dval_n, b_dbb_n, b_ci_n, b_gbl_n, b_br1_n, b_bg1_n,
		output b_dbg1_n, b_rst_n, b_addr_oe, b_data_oe, b_resp_oe,
		output b_dresp_oe, b_arb_oe, b_rst_oe, b_bg_ext_n, b_dbg_ext_n,
		output b_addr, b_ap, b_data, b_dp, b_tsiz, b_tt
	);
	modport processor
	(
		input ts_n, aack_n, artry_n, tbst_n, ta_n, tea_n, dval_n, dbb_n,
		input bg1_n, dbg1_n, rst_n, addr, data, tsiz, tt, ci_n, gbl_n,
		output p_ts_n, p_tbst_n, p_ta_n, p_tea_n, p_dval_n, p_aack_n,
		output p_artry_n, p_dbb_n, p_br1_n, p_rst_n, p_addr_oe, p_data_oe,
		output p_resp_oe, p_dresp_oe, p_br_oe, p_rst_oe, p_addr, p_ap,
		output p_data, p_dp, p_tsiz, p_tt
	);
endinterface : pbus_if
`default_nettype wire

// File: core/pbus_proc_end.sv
// Processor end: a master issuing transfers and a slave answering the bridge
`timescale 1ns/100ps
`default_nettype none
`include "pbus_defines.svh"
module pbus_proc_end
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	pbus_if.processor bus,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [`PB_ADDR_W-1:0] cmd_addr_i,
	input wire logic [`PB_TSIZ_W-1:0] cmd_size_i,
	input wire logic [`PB_TT_W-1:0] cmd_type_i,
	input wire logic cmd_burst_i,
	input wire logic [`PB_DATA_W-1:0] cmd_wdata_i,
	output logic done_o,
	output logic err_o,
	output logic retried_o,
	output logic [`PB_DATA_W-1:0] rdata_o,
	input wire logic reset_config_strobe_n_i,
	input wire logic [`PB_DATA_W-1:0] slv_rdata_i
);
	pbus_pkg::mst_state_t st_ff, nxt_st;
	logic [2:0] beat_ff, nxt_beat;
	logic [`PB_ADDR_W-1:0] addr_ff, nxt_addr;
	logic [`PB_TSIZ_W-1:0] size_ff, nxt_size;
	logic [`PB_TT_W-1:0] type_ff, nxt_type;
	logic burst_ff, nxt_burst, done_ff, nxt_done, err_ff, nxt_err;
	logic retry_ff, nxt_retry;
	logic [`PB_DATA_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic is_read;
	logic slv_busy_ff, nxt_slv_busy, slv_rd_ff, nxt_slv_rd;
	logic [2:0] slv_left_ff, nxt_slv_left;

	////////////////////////////////////////////////////////////////////
	// Master sequencing
	assign is_read = type_ff[`PB_TT_READ_BIT];
	always_comb
	begin
		nxt_st = st_ff;
		{nxt_beat, nxt_addr, nxt_size, nxt_type} =
			{beat_ff, addr_ff, size_ff, type_ff};
		{nxt_burst, nxt_wdata, nxt_rdata} = {burst_ff, wdata_ff, rdata_ff};
		{nxt_done, nxt_err, nxt_retry} = 3'h0;
		case (st_ff)
			pbus_pkg::ST_IDLE:
				if (cmd_valid_i)
				begin
					nxt_addr = cmd_addr_i;
					nxt_size = cmd_size_i;
					nxt_type = cmd_type_i;
					nxt_burst = cmd_burst_i;
					nxt_wdata = cmd_wdata_i;
					nxt_st = pbus_pkg::ST_REQ;
				end
			pbus_pkg::ST_REQ:
				if (!bus.bg1_n && bus.dbb_n)
					nxt_st = pbus_pkg::ST_ADDR;
			pbus_pkg::ST_ADDR:
				if (!bus.artry_n)
					nxt_st = pbus_pkg::ST_REQ; // Retry later [R02]
				else if (!bus.aack_n)
				begin
					nxt_beat = 3'h0;
					nxt_st = pbus_pkg::ST_DATA;
				end
			pbus_pkg::ST_DATA:
				if (!bus.artry_n)
				begin
					nxt_retry = 1'b1;
					nxt_st = pbus_pkg::ST_REQ; // [R02]
				end
				else if (!bus.tea_n)
				begin
					nxt_err = 1'b1;
					nxt_st = pbus_pkg::ST_DONE;
				end
				else if (!bus.ta_n)
				begin
					if (is_read)
						nxt_rdata = bus.data;
					nxt_beat = beat_ff + 3'h1;
					// Four beats end a burst [R19]
					if (!burst_ff || beat_ff == `PB_BURST_BEATS - 3'h1)
					begin
						nxt_done = 1'b1;
						nxt_st = pbus_pkg::ST_DONE;
					end
				end
			pbus_pkg::ST_DONE:
				nxt_st = pbus_pkg::ST_IDLE;
			default:
				nxt_st = pbus_pkg::ST_IDLE;
		endcase
	end

	// Slave side: answers transfers that the bridge masters
	always_comb
	begin
		nxt_slv_busy = slv_busy_ff;
		nxt_slv_rd = slv_rd_ff;
		nxt_slv_left = slv_left_ff;
		if (!slv_busy_ff && !bus.ts_n && st_ff != pbus_pkg::ST_ADDR)
		begin
			nxt_slv_busy = 1'b1;
			nxt_slv_rd = bus.tt[`PB_TT_READ_BIT];
			nxt_slv_left = bus.tbst_n ? 3'h1 : `PB_BURST_BEATS;
		end
		else if (slv_busy_ff)
		begin
			nxt_slv_left = slv_left_ff - 3'h1;
			if (slv_left_ff == 3'h1)
				nxt_slv_busy = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_ff <= pbus_pkg::ST_IDLE;
			{beat_ff, slv_left_ff, size_ff, type_ff} <= 15'h0000;
			{addr_ff, wdata_ff, rdata_ff} <= 160'h0;
			{burst_ff, done_ff, err_ff, retry_ff} <= 4'h0;
			{slv_busy_ff, slv_rd_ff} <= 2'h0;
		end
		else
		begin
			st_ff <= nxt_st;
			{beat_ff, slv_left_ff, size_ff, type_ff} <=
				{nxt_beat, nxt_slv_left, nxt_size, nxt_type};
			{addr_ff, wdata_ff, rdata_ff} <= {nxt_addr, nxt_wdata, nxt_rdata};
			{burst_ff, done_ff, err_ff, retry_ff} <=
				{nxt_burst, nxt_done, nxt_err, nxt_retry};
			{slv_busy_ff, slv_rd_ff} <= {nxt_slv_busy, nxt_slv_rd};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drive for the master role
	assign cmd_ready_o = (st_ff == pbus_pkg::ST_IDLE);
	assign done_o = done_ff;
	assign err_o = err_ff;
	assign retried_o = retry_ff;
	assign rdata_o = rdata_ff;
	assign bus.p_br_oe = 1'b1;
	assign bus.p_br1_n = !(st_ff == pbus_pkg::ST_REQ);
	assign bus.p_addr_oe = (st_ff == pbus_pkg::ST_ADDR);
	assign bus.p_ts_n = !(st_ff == pbus_pkg::ST_ADDR); // [R22]
	assign bus.p_addr = addr_ff;
	assign bus.p_tsiz = size_ff; // [R22]
	assign bus.p_tt = type_ff;
	assign bus.p_tbst_n = !burst_ff; // [R20]
	assign bus.p_ap = {^addr_ff[31:24], ^addr_ff[23:16], ^addr_ff[15:8],
		^addr_ff[7:0]}; // [R03]
	assign bus.p_dbb_n = !(st_ff == pbus_pkg::ST_DATA); // [R11]
	// Data and parity: master on writes, slave on reads [R13]
	assign bus.p_data_oe = (st_ff == pbus_pkg::ST_DATA && !is_read) ||
		(slv_busy_ff && slv_rd_ff);
	assign bus.p_data = slv_busy_ff ? slv_rdata_i : wdata_ff;
	for (genvar g = 0; g < `PB_DPAR_W; g++)
	begin : g_dpar
		assign bus.p_dp[g] = ^bus.p_data[g*8 +: 8];
	end
	// Slave answers: acknowledge address, then one beat per cycle [R01]
	assign bus.p_resp_oe = slv_busy_ff || (!bus.ts_n &&
		st_ff != pbus_pkg::ST_ADDR);
	assign bus.p_aack_n = slv_busy_ff; // [R01]
	assign bus.p_artry_n = 1'b1;
	assign bus.p_dresp_oe = slv_busy_ff;
	assign bus.p_ta_n = !slv_busy_ff; // [R19]
	assign bus.p_tea_n = 1'b1;
	assign bus.p_dval_n = !(slv_busy_ff && slv_rd_ff); // [R14]
	// Config strobe holds the reset-config input to the bridge [R17]
	assign bus.p_rst_oe = !reset_config_strobe_n_i;
	assign bus.p_rst_n = 1'b0;
endmodule : pbus_proc_end
`default_nettype wire

// File: bench/pbus_link_props.sv
// Concurrent checks on the processor bus link between both ends
`timescale 1ns/100ps
`default_nettype none
`include "pbus_defines.svh"
module pbus_link_props
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ts_n,
	input wire logic aack_n,
	input wire logic tbst_n,
	input wire logic ta_n,
	input wire logic tea_n,
	input wire logic dval_n,
	input wire logic dbb_n,
	input wire logic gbl_n,
	input wire logic [`PB_TT_W-1:0] tt,
	input wire logic b_addr_oe,
	input wire logic p_addr_oe,
	input wire logic b_arb_oe,
	input wire logic b_bg1_n,
	input wire logic b_dbg1_n,
	input wire logic [1:0] b_bg_ext_n,
	input wire logic [1:0] b_dbg_ext_n
);
	// One clock; idle in reset
	default clocking dc @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	///////////////////////////////////////////////////////////////////////////
	// Address tenure
	property p_aack; !ts_n |-> !aack_n; endproperty
	a_aack: assert property (p_aack) else $error("start without ack");
	property p_ts_one; !ts_n |=> ts_n; endproperty
	a_ts_one: assert property (p_ts_one) else $error("start held");
	property p_no_fight; !(b_addr_oe && p_addr_oe); endproperty
	a_no_fight: assert property (p_no_fight) else $error("two addr");
	// Data beats
	property p_dbb; !ta_n |-> !dbb_n; endproperty
	a_dbb: assert property (p_dbb) else $error("beat without busy");
	property p_dval; !dval_n |-> !ta_n; endproperty
	a_dval: assert property (p_dval) else $error("stray valid");
	property p_burst;
		!ts_n && !tbst_n |=> !tea_n or ((!ta_n) [*4] ##1 ta_n);
	endproperty
	a_burst: assert property (p_burst) else $error("burst beats");
	property p_single;
		!ts_n && tbst_n |=> (!ta_n || !tea_n) ##1 ta_n;
	endproperty
	a_single: assert property (p_single) else $error("single beat");
	// Error is one cycle and carries no data
	property p_tea; !tea_n |-> ta_n ##1 tea_n; endproperty
	a_tea: assert property (p_tea) else $error("error shape");
	// Coherent bridge tenures must be snooped
	property p_gbl;
		!ts_n && b_addr_oe && tt[`PB_TT_COHERENT_BIT] |-> !gbl_n;
	endproperty
	a_gbl: assert property (p_gbl) else $error("global missing");
	// Internal arbiter never grants two agents at once
	property p_grant;
		b_arb_oe |-> $onehot0({~b_bg1_n, ~b_bg_ext_n})
			&& $onehot0({~b_dbg1_n, ~b_dbg_ext_n});
	endproperty
	a_grant: assert property (p_grant) else $error("double grant");
	// Main scenarios reached
	c_burst: cover property (!ts_n && !tbst_n);
	c_tea: cover property (!tea_n);
	c_ext: cover property (b_arb_oe && !b_bg_ext_n[0]);
endmodule : pbus_link_props
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench joining bridge end and processor end
`timescale 1ns/100ps
`default_nettype none
`include "pbus_defines.svh"
module tb;
	logic clk = 1'b0, rstn = 1'b0, iarb = 1'b1, le = 1'b0, rdir = 1'b1;
	logic fast = 1'b1, pstb = 1'b1, b_v = 1'b0, p_v = 1'b0, inh = 1'b0;
	logic bst = 1'b0, got_err, last_ci, last_gbl;
	logic [1:0] xreq = 2'h3;
	logic [31:0] a = 32'h0, b_sa;
	logic [3:0] sz = 4'h8;
	logic [4:0] tt = 5'h00, ev;
	logic [63:0] wd = 64'hA5A5_0000_1234_5678, flt = 64'h5A5A_5A5A_5A5A_5A5A;
	logic [63:0] b_srd = 64'h1122_3344_5566_7788, b_rd, b_sw, p_rd;
	logic [63:0] p_srd = 64'h99AA_BBCC_DDEE_F011;
	logic b_fast, b_ld, b_rdy, b_done, b_err, b_wv, p_rdy, p_done, p_err;
	logic [3:0] les [5] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h2};
	int failures = 0, comparisons = 0, beats = 0, wcnt = 0, c0, w0;
	pbus_if bus();
	///////////////////////////////////////////////////////////////////////////
	// Clock; released lines toggle
	always #20 clk = ~clk;
	always @(posedge clk) flt <= ~flt;
	// Enabled driver wins, else pull-up or toggling filler
	wire logic ba = bus.b_addr_oe, pa = bus.p_addr_oe;
	wire logic bt = bus.b_dresp_oe, pt = bus.p_dresp_oe;
	wire logic br = bus.b_resp_oe, pr = bus.p_resp_oe;
	wire logic bd = bus.b_data_oe, pd = bus.p_data_oe;
	assign bus.ts_n = ba ? bus.b_ts_n : pa ? bus.p_ts_n : 1'b1;
	assign bus.tbst_n = ba ? bus.b_tbst_n : pa ? bus.p_tbst_n : 1'b1;
	assign bus.addr = ba ? bus.b_addr : pa ? bus.p_addr : flt[31:0];
	assign bus.ap = ba ? bus.b_ap : pa ? bus.p_ap : 4'hF;
	assign bus.tsiz = ba ? bus.b_tsiz : pa ? bus.p_tsiz : flt[3:0];
	assign bus.tt = ba ? bus.b_tt : pa ? bus.p_tt : flt[4:0];
	assign bus.ci_n = ba ? bus.b_ci_n : 1'b1;
	assign bus.gbl_n = ba ? bus.b_gbl_n : 1'b1;
	assign bus.aack_n = br ? bus.b_aack_n : pr ? bus.p_aack_n : 1'b1;
	assign bus.artry_n = br ? bus.b_artry_n : pr ? bus.p_artry_n : 1'b1;
	assign bus.ta_n = bt ? bus.b_ta_n : pt ? bus.p_ta_n : 1'b1;
	assign bus.tea_n = bt ? bus.b_tea_n : pt ? bus.p_tea_n : 1'b1;
	assign bus.dval_n = bt ? bus.b_dval_n : pt ? bus.p_dval_n : 1'b1;
	assign bus.data = bd ? bus.b_data : pd ? bus.p_data : flt;
	assign bus.dp = bd ? bus.b_dp : pd ? bus.p_dp : flt[7:0];
	assign bus.dbb_n = bus.b_dbb_n & bus.p_dbb_n;
	assign bus.br1_n = bus.b_arb_oe ? (!bus.p_br_oe | bus.p_br1_n) :
		bus.b_br1_n;
	// Outside arbiter grants at once
	assign bus.bg1_n = bus.b_arb_oe ? bus.b_bg1_n : bus.br1_n;
	assign bus.dbg1_n = bus.b_arb_oe ? bus.b_dbg1_n : 1'b0;
	assign bus.rst_n = (!bus.b_rst_oe | bus.b_rst_n) &
		(!bus.p_rst_oe | bus.p_rst_n);
	assign bus.br_ext_n = xreq;
	assign ev = {~bus.b_bg_ext_n[0], b_done | b_err, b_rdy, p_done | p_err,
		p_rdy};
	// Both ends and the checker
	pbus_bridge_end i_pbus_bridge_end
	(
		.core_clk_i(clk), .reset_n_i(rstn), .bus(bus), .internal_arb_i(iarb),
		.little_endian_i(le), .reset_direction_strap_i(rdir),
		.pll_range_strap_i(fast), .pll_fast_range_o(b_fast),
		.options_loaded_o(b_ld), .mst_valid_i(b_v), .mst_ready_o(b_rdy),
		.mst_addr_i(a), .mst_size_i(sz), .mst_type_i(tt), .mst_burst_i(bst),
		.mst_inhibit_i(inh), .mst_wdata_i(wd), .mst_done_o(b_done),
		.mst_err_o(b_err), .mst_rdata_o(b_rd), .slv_wvalid_o(b_wv),
		.slv_addr_o(b_sa), .slv_wdata_o(b_sw), .slv_rdata_i(b_srd)
	);
	pbus_proc_end i_pbus_proc_end
	(
		.core_clk_i(clk), .reset_n_i(rstn), .bus(bus), .cmd_valid_i(p_v),
		.cmd_ready_o(p_rdy), .cmd_addr_i(a), .cmd_size_i(sz), .cmd_type_i(tt),
		.cmd_burst_i(bst), .cmd_wdata_i(wd), .done_o(p_done), .err_o(p_err),
		.retried_o(), .rdata_o(p_rd), .reset_config_strobe_n_i(pstb),
		.slv_rdata_i(p_srd)
	);
	pbus_link_props i_props
	(
		.core_clk_i(clk), .reset_n_i(rstn), .ts_n(bus.ts_n), .tt(bus.tt),
		.aack_n(bus.aack_n), .tbst_n(bus.tbst_n), .ta_n(bus.ta_n),
		.tea_n(bus.tea_n), .dval_n(bus.dval_n), .dbb_n(bus.dbb_n),
		.gbl_n(bus.gbl_n), .b_addr_oe(ba), .p_addr_oe(pa),
		.b_arb_oe(bus.b_arb_oe), .b_bg1_n(bus.b_bg1_n), .b_dbg1_n(bus.b_dbg1_n),
		.b_bg_ext_n(bus.b_bg_ext_n), .b_dbg_ext_n(bus.b_dbg_ext_n)
	);
	// Counts beats and written words
	always @(posedge clk)
	begin
		beats += (bus.ta_n === 1'b0);
		wcnt += (b_wv === 1'b1);
		if (bus.ts_n === 1'b0 && ba === 1'b1)
			{last_gbl, last_ci} = {bus.gbl_n, bus.ci_n};
	end
	///////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	// Bounded wait on one event bit
	task automatic wt(input int k);
		int n;
		for (n = 0; ev[k] !== 1'b1 && n < 60; n++)
			@(posedge clk) #1;
		failures += (n == 60);
		if (n == 60)
			report_and_stop();
	endtask : wt
	// Transfer: k 0 processor end, 2 bridge end
	task automatic xfer(input int k, input logic [31:0] ad, input logic [3:0] s,
		input logic [4:0] t, input logic b);
		{a, sz, tt, bst} = {ad, s, t, b};
		{c0, w0} = {beats, wcnt};
		{p_v, b_v} = {k == 0, k != 0};
		wt(k);
		@(posedge clk) #1;
		{p_v, b_v} = 2'h0;
		wt(k + 1);
		got_err = p_err | b_err;
		@(posedge clk) #1;
	endtask : xfer
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk) #1;
		chk(bus.rst_n, 1'b0);
		rstn = 1'b1;
		repeat (2) @(posedge clk) #1;
		chk(b_ld, 1'b1);
		chk(b_fast, 1'b1);
		xfer(0, 32'h0000_0100, 4'h8, 5'h00, 1'b0);
		chk(wcnt - w0, 1);
		chk(b_sa, 32'h0000_0100);
		chk(b_sw, wd);
		xfer(0, 32'h0000_0200, 4'h8, 5'h00, 1'b1);
		chk(wcnt - w0, 4);
		chk(beats - c0, 4);
		xfer(0, 32'h0000_0300, 4'h8, 5'h08, 1'b0);
		chk(p_rd, b_srd);
		inh = 1'b1;
		xfer(2, 32'h0000_0400, 4'h8, 5'h09, 1'b0);
		chk(b_rd, p_srd);
		chk({last_gbl, last_ci}, 2'h0);
		inh = 1'b0;
		xfer(2, 32'h0000_0500, 4'h8, 5'h00, 1'b1);
		chk(beats - c0, 4);
		chk({last_gbl, last_ci}, 2'h3);
		iarb = 1'b0;
		xfer(2, 32'h0000_0600, 4'h8, 5'h08, 1'b0);
		chk({bus.b_arb_oe, got_err}, 2'h0);
		chk(b_rd, p_srd);
		iarb = 1'b1;
		xreq = 2'h2;
		wt(4);
		chk(bus.b_bg_ext_n[1] & bus.b_bg1_n, 1'b1);
		xreq = 2'h3;
		le = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			xfer(0, 32'h0000_0700 + (i == 4), les[i], 5'h00, 1'b0);
			chk({got_err, wcnt - w0}, {1'b1, 32'h0});
		end
		xfer(0, 32'h0000_0702, 4'h2, 5'h00, 1'b0);
		chk(got_err, 1'b0);
		{le, rdir, fast, rstn} = 4'h0;
		repeat (4) @(posedge clk) #1;
		chk(bus.rst_n, 1'b1);
		rstn = 1'b1;
		@(posedge clk) #1;
		chk(b_ld, 1'b0);
		pstb = 1'b0;
		@(posedge clk) #1;
		pstb = 1'b1;
		repeat (3) @(posedge clk) #1;
		chk(b_ld, 1'b1);
		chk(b_fast, 1'b0);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
